// file: ssrh_pkg.sv
// constants shared by the status register hierarchy
`default_nettype none

package ssrh_pkg;

	// width of one generic register part, and of the status byte
	localparam int REG_W = 16;
	localparam int BYTE_W = 8;

	// register selects on the command access port
	localparam logic [2:0] SEL_QUES = 3'h0;
	localparam logic [2:0] SEL_OPER = 3'h1;
	localparam logic [2:0] SEL_STD_EVT = 3'h2;
	localparam logic [2:0] SEL_STD_MASK = 3'h3;
	localparam logic [2:0] SEL_SUMMARY = 3'h4;
	localparam logic [2:0] SEL_REQ_MASK = 3'h5;
	localparam logic [2:0] SEL_SPOLL = 3'h6;

	// part selects inside a generic register
	localparam logic [2:0] PART_CURRENT = 3'h0;
	localparam logic [2:0] PART_RISE = 3'h1;
	localparam logic [2:0] PART_FALL = 3'h2;
	localparam logic [2:0] PART_EVENT = 3'h3;
	localparam logic [2:0] PART_MASK = 3'h4;

	// reset values of the generic parts (bit 15 not stored)
	localparam logic [14:0] RISE_RST = 15'h7FFF;
	localparam logic [14:0] FALL_RST = 15'h0000;
	localparam logic [14:0] EVT_RST = 15'h0000;
	localparam logic [14:0] MASK_RST = 15'h0000;

	// reset values of the byte wide registers
	localparam logic [7:0] BYTE_RST = 8'h00;

	// status byte bit positions
	localparam int BIT_ERRQ = 2;
	localparam int BIT_QUES = 3;
	localparam int BIT_MSG = 4;
	localparam int BIT_STD_SUM = 5;
	localparam int BIT_SUMMARY = 6;
	localparam int BIT_OPER = 7;

	// request mask bits that take part in the request decision
	localparam logic [7:0] REQ_MASK_USED = 8'hBF;

endpackage

`default_nettype wire

// file: ssrh_reg.sv
// one generic five part status register with sum bit
`default_nettype none

module ssrh_reg
	import ssrh_pkg::*;
#(
	parameter int W = REG_W
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [W-2:0] cond_in,
	input wire logic acc_wr,
	input wire logic acc_rd,
	input wire logic [2:0] acc_part,
	input wire logic [W-1:0] acc_wdata,
	output logic [W-1:0] part_rdata,
	output logic sum_out
);

	// stored width: the top bit of every part is always zero
	localparam int CW = W - 1;

	// all state of the register
	typedef struct packed {
		logic [CW-1:0] cur;
		logic [CW-1:0] rise;
		logic [CW-1:0] fall;
		logic [CW-1:0] evt;
		logic [CW-1:0] mask;
		logic sum;
	} ssrh_reg_st_t;

	ssrh_reg_st_t s_q; // registered state
	ssrh_reg_st_t s_d; // next state
	logic [CW-1:0] rise_hit; // filtered rising edges
	logic [CW-1:0] fall_hit; // filtered falling edges
	logic [CW-1:0] hit; // any filtered edge
	logic [CW-1:0] wdata_lo; // stored bits of write data

	////////////////////////////////////////////////////////////////
	// transition filters
	// rising edge filter
	assign rise_hit = cond_in & ~s_q.cur & s_q.rise;
	assign fall_hit = ~cond_in & s_q.cur & s_q.fall;
	assign hit = rise_hit | fall_hit;
	assign wdata_lo = acc_wdata[CW-1:0];

	////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		s_d = s_q;
		s_d.cur = cond_in;
		if (acc_rd && acc_part == PART_EVENT) begin
			s_d.evt = '0;
		end
		s_d.evt = s_d.evt | hit;
		// current and event parts ignore writes
		if (acc_wr) begin
			case (acc_part)
				PART_RISE: begin
					s_d.rise = wdata_lo;
				end
				PART_FALL: begin
					s_d.fall = wdata_lo;
				end
				PART_MASK: begin
					s_d.mask = wdata_lo;
				end
				default: begin
					// current, event and unused parts take no writes
				end
			endcase
		end
		s_d.sum = |(s_d.evt & s_d.mask);
	end

	////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_q.cur <= '0;
			s_q.rise <= RISE_RST;
			s_q.fall <= FALL_RST;
			s_q.evt <= EVT_RST;
			s_q.mask <= MASK_RST;
			s_q.sum <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// read mux, reads have no side effect here
	// top bit always reads zero
	always_comb begin
		case (acc_part)
			PART_CURRENT: part_rdata = {1'b0, s_q.cur};
			PART_RISE: part_rdata = {1'b0, s_q.rise};
			PART_FALL: part_rdata = {1'b0, s_q.fall};
			PART_EVENT: part_rdata = {1'b0, s_q.evt};
			PART_MASK: part_rdata = {1'b0, s_q.mask};
			default: part_rdata = '0;
		endcase
	end

	// sum bit feeds the level above
	assign sum_out = s_q.sum;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_msb_zero;
		part_rdata[W-1] == 1'b0;
	endproperty
	a_msb_zero: assert property (p_msb_zero)
		else $error("top bit of a part reads as one");

	property p_cur_mirror;
		1'b1 |=> s_q.cur == $past(cond_in);
	endproperty
	a_cur_mirror: assert property (p_cur_mirror)
		else $error("current part does not follow inputs");

	property p_rise_latch;
		1'b1 |=> (s_q.evt & $past(rise_hit)) == $past(rise_hit);
	endproperty
	a_rise_latch: assert property (p_rise_latch)
		else $error("filtered rising edge not latched");

	property p_fall_latch;
		1'b1 |=> (s_q.evt & $past(fall_hit)) == $past(fall_hit);
	endproperty
	a_fall_latch: assert property (p_fall_latch)
		else $error("filtered falling edge not latched");

	property p_no_stray_event;
		1'b1 |=> (s_q.evt & ~$past(s_q.evt) & ~$past(hit)) == '0;
	endproperty
	a_no_stray_event: assert property (p_no_stray_event)
		else $error("event bit set without filtered edge");

	property p_read_clear;
		acc_rd && acc_part == PART_EVENT |=> s_q.evt == $past(hit);
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("event read did not clear the part");

	property p_sum;
		sum_out == |(s_q.evt & s_q.mask);
	endproperty
	a_sum: assert property (p_sum)
		else $error("sum bit disagrees with event and mask");

	property p_mask_write;
		acc_wr && acc_part == PART_MASK |=> s_q.mask == $past(wdata_lo);
	endproperty
	a_mask_write: assert property (p_mask_write)
		else $error("mask write not stored");

endmodule

`default_nettype wire

// file: ssrh_top.sv
// status byte, request logic and the two generic registers
`default_nettype none

// Functional notes
// - five sixteen bit parts, shared bit meaning
// - top bit of each part reads zero
// - current part follows condition inputs
// - current part read only, reads harmless
// - rising edge sets event if filter set
// - falling edge sets event if filter set
// - both filters host writable and readable
// - event part holds filtered edges only
// - event part read only, read clears
// - sum is or of event and mask
// - mask host writable, reads harmless
// - sum bit drives its status byte bit
// - status bit six is masked summary
// - request mask bit six ignored
// - masked rising status bit raises request
// - host uses status query and poll
// - bits zero one unused, bit two errors
// - bit three is questionable sum
// - bit four shows pending output message
// - bit five is standard event summary
// - bit seven is operation sum
module ssrh_top
	import ssrh_pkg::*;
#(
	parameter int W = REG_W,
	parameter int BW = BYTE_W
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [W-2:0] ques_cond,
	input wire logic [W-2:0] oper_cond,
	input wire logic [BW-1:0] std_event_in,
	input wire logic err_entry_push,
	input wire logic err_queue_nonempty,
	input wire logic output_message_pending,
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire logic [2:0] acc_reg,
	input wire logic [2:0] acc_part,
	input wire logic [W-1:0] acc_wdata,
	output logic acc_ack_q,
	output logic [W-1:0] acc_rdata_q,
	output logic [BW-1:0] summary_status_byte_q,
	output logic service_request_q
);

	////////////////////////////////////////////////////////////////
	// state and helper signals

	// all state of the top level
	typedef struct packed {
		logic [BW-1:0] std_evt; // standard event latch
		logic [BW-1:0] std_mask; // standard event mask
		logic [BW-1:0] req_mask; // request mask byte
		logic [BW-1:0] sbyte; // summary status byte
		logic srq; // pending service request
		logic ack; // access answered
		logic [W-1:0] rdata; // read answer
	} ssrh_top_st_t;

	ssrh_top_st_t s_q; // registered state
	ssrh_top_st_t s_d; // next state

	// access strobes per generic register
	logic ques_wr; // write into questionable register
	logic ques_rd; // read of questionable register
	logic oper_wr; // write into operation register
	logic oper_rd; // read of operation register

	// generic register results
	logic [W-1:0] ques_rdata; // questionable read data
	logic [W-1:0] oper_rdata; // operation read data
	logic ques_sum; // questionable sum bit
	logic oper_sum; // operation sum bit

	// request decision
	logic [BW-1:0] byte_base; // status byte without summary
	logic [BW-1:0] byte_rise; // status bits going high
	logic [BW-1:0] push_vec; // error entry as bit two event
	logic master_summary_flag; // bit six value
	logic srq_trig; // new request this cycle
	logic standard_event_summary; // bit five value
	logic host_rd; // any host read
	logic host_wr; // any host write

	////////////////////////////////////////////////////////////////
	// access decode

	// host read and write qualifiers
	assign host_rd = acc_valid && !acc_write;
	assign host_wr = acc_valid && acc_write;

	// strobes for the generic registers
	assign ques_wr = host_wr && acc_reg == SEL_QUES;
	assign ques_rd = host_rd && acc_reg == SEL_QUES;
	assign oper_wr = host_wr && acc_reg == SEL_OPER;
	assign oper_rd = host_rd && acc_reg == SEL_OPER;

	////////////////////////////////////////////////////////////////
	// generic registers of the lower level

	ssrh_reg #(
		.W(W)
	) u_ques (
		.sys_clk(sys_clk),
		.reset(reset),
		.cond_in(ques_cond),
		.acc_wr(ques_wr),
		.acc_rd(ques_rd),
		.acc_part(acc_part),
		.acc_wdata(acc_wdata),
		.part_rdata(ques_rdata),
		.sum_out(ques_sum)
	);

	ssrh_reg #(
		.W(W)
	) u_oper (
		.sys_clk(sys_clk),
		.reset(reset),
		.cond_in(oper_cond),
		.acc_wr(oper_wr),
		.acc_rd(oper_rd),
		.acc_part(acc_part),
		.acc_wdata(acc_wdata),
		.part_rdata(oper_rdata),
		.sum_out(oper_sum)
	);

	////////////////////////////////////////////////////////////////
	// next state of the top level
	always_comb begin
		s_d = s_q;
		// every access is answered one cycle later
		s_d.ack = acc_valid;

		// standard event latch, clear on read
		if (host_rd && acc_reg == SEL_STD_EVT) begin
			s_d.std_evt = '0;
		end
		// events win over the read clear
		s_d.std_evt = s_d.std_evt | std_event_in;

		// mask writes
		if (host_wr) begin
			case (acc_reg)
				SEL_STD_MASK: begin
					s_d.std_mask = acc_wdata[BW-1:0];
				end
				SEL_REQ_MASK: begin
					s_d.req_mask = acc_wdata[BW-1:0];
				end
				default: begin
					// status byte and poll are read only
				end
			endcase
		end

		standard_event_summary = |(s_d.std_evt & s_d.std_mask);

		// status byte sources
		byte_base = '0;
		byte_base[BIT_ERRQ] = err_queue_nonempty;
		byte_base[BIT_QUES] = ques_sum;
		byte_base[BIT_MSG] = output_message_pending;
		byte_base[BIT_STD_SUM] = standard_event_summary;
		byte_base[BIT_OPER] = oper_sum;

		// bit six of the mask takes no part
		master_summary_flag = |(byte_base & s_d.req_mask & REQ_MASK_USED);
		// summary bit of the status byte
		s_d.sbyte = byte_base;
		s_d.sbyte[BIT_SUMMARY] = master_summary_flag;

		// every error entry counts as a new event
		push_vec = '0;
		push_vec[BIT_ERRQ] = err_entry_push;
		// masked zero to one raises request
		byte_rise = (byte_base & ~s_q.sbyte) | push_vec;
		srq_trig = |(byte_rise & s_d.req_mask & REQ_MASK_USED);

		// serial poll clears the request, new trigger wins
		if (host_rd && acc_reg == SEL_SPOLL) begin
			s_d.srq = 1'b0;
		end
		if (srq_trig) begin
			s_d.srq = 1'b1;
		end

		// read answer, taken from the state before this cycle
		if (host_rd) begin
			case (acc_reg)
				SEL_QUES: begin
					s_d.rdata = ques_rdata;
				end
				SEL_OPER: begin
					s_d.rdata = oper_rdata;
				end
				SEL_STD_EVT: begin
					s_d.rdata = {{(W-BW){1'b0}}, s_q.std_evt};
				end
				SEL_STD_MASK: begin
					s_d.rdata = {{(W-BW){1'b0}}, s_q.std_mask};
				end
				// status byte by query or poll
				SEL_SUMMARY, SEL_SPOLL: begin
					s_d.rdata = {{(W-BW){1'b0}}, s_q.sbyte};
				end
				SEL_REQ_MASK: begin
					s_d.rdata = {{(W-BW){1'b0}}, s_q.req_mask};
				end
				default: begin
					s_d.rdata = '0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_q.std_evt <= BYTE_RST;
			s_q.std_mask <= BYTE_RST;
			s_q.req_mask <= BYTE_RST;
			s_q.sbyte <= BYTE_RST;
			s_q.srq <= 1'b0;
			s_q.ack <= 1'b0;
			s_q.rdata <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs, straight from the state register
	assign acc_ack_q = s_q.ack;
	assign acc_rdata_q = s_q.rdata;
	assign summary_status_byte_q = s_q.sbyte;
	assign service_request_q = s_q.srq;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// summary bit tied to masked byte
	property p_summary;
		summary_status_byte_q[BIT_SUMMARY] ==
			|(summary_status_byte_q & s_q.req_mask & REQ_MASK_USED);
	endproperty
	a_summary: assert property (p_summary)
		else $error("summary bit disagrees with masked byte");

	// mask bit six alone never sets the summary bit
	property p_mask_six;
		s_q.req_mask == 8'h40 |-> !summary_status_byte_q[BIT_SUMMARY];
	endproperty
	a_mask_six: assert property (p_mask_six)
		else $error("mask bit six caused a summary");

	// a trigger raises the request next cycle
	property p_srq_set;
		srq_trig |=> service_request_q;
	endproperty
	a_srq_set: assert property (p_srq_set)
		else $error("request not raised after masked rise");

	// a request only appears after a trigger
	property p_srq_cause;
		$rose(service_request_q) |-> $past(srq_trig);
	endproperty
	a_srq_cause: assert property (p_srq_cause)
		else $error("request raised without a cause");

	// error queue level and each entry
	property p_errq;
		err_entry_push && s_q.req_mask[BIT_ERRQ] |=>
			service_request_q && s_q.sbyte[BIT_ERRQ] ==
			$past(err_queue_nonempty);
	endproperty
	a_errq: assert property (p_errq)
		else $error("error entry did not request service");

	// unused status bits stay low
	property p_unused;
		summary_status_byte_q[1:0] == 2'b00;
	endproperty
	a_unused: assert property (p_unused)
		else $error("unused status byte bits set");

	// questionable and operation sums one cycle on
	property p_sums;
		1'b1 |=> summary_status_byte_q[BIT_QUES] == $past(ques_sum)
			&& summary_status_byte_q[BIT_OPER] == $past(oper_sum);
	endproperty
	a_sums: assert property (p_sums)
		else $error("status byte lost a lower sum bit");

	// message pending bit follows its source
	property p_msg;
		1'b1 |=> summary_status_byte_q[BIT_MSG] ==
			$past(output_message_pending);
	endproperty
	a_msg: assert property (p_msg)
		else $error("message pending bit out of step");

	// standard event summary bit
	property p_std_sum;
		summary_status_byte_q[BIT_STD_SUM] ==
			|(s_q.std_evt & s_q.std_mask);
	endproperty
	a_std_sum: assert property (p_std_sum)
		else $error("standard event summary wrong");

	// standard event read keeps simultaneous events
	property p_std_keep;
		host_rd && acc_reg == SEL_STD_EVT |=>
			s_q.std_evt == $past(std_event_in);
	endproperty
	a_std_keep: assert property (p_std_keep)
		else $error("standard event lost at read clear");

	// main scenarios
	c_srq: cover property (srq_trig ##1 service_request_q);
	c_poll: cover property (service_request_q && host_rd
		&& acc_reg == SEL_SPOLL);
	c_ques_up: cover property ($rose(ques_sum) ##1 service_request_q);
	c_std_read: cover property (host_rd && acc_reg == SEL_STD_EVT
		&& s_q.std_evt != '0);

endmodule

`default_nettype wire

// file: ssrh_host_model.sv
// remote controller model issuing command accesses
`default_nettype none

module ssrh_host_model
	import ssrh_pkg::*;
(
	input wire logic sys_clk,
	input wire logic acc_ack_q,
	output logic acc_valid,
	output logic acc_write,
	output logic [2:0] acc_reg,
	output logic [2:0] acc_part,
	output logic [REG_W-1:0] acc_wdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle lines at time zero
	initial begin
		acc_valid = 1'b0;
		acc_write = 1'b0;
		acc_reg = 3'h0;
		acc_part = 3'h0;
		acc_wdata = 16'h0000;
	end

	// one query or setting at a time
	task automatic access(input logic w, input logic [2:0] r,
		input logic [2:0] p, input logic [REG_W-1:0] d);
		int n;
		@(negedge sys_clk);
		acc_valid = 1'b1;
		acc_write = w;
		acc_reg = r;
		acc_part = p;
		acc_wdata = d;
		@(negedge sys_clk);
		// released lines show the inverse of the last value
		acc_valid = 1'b0;
		acc_write = ~w;
		acc_reg = ~r;
		acc_part = ~p;
		acc_wdata = ~d;
		n = 0;
		while (acc_ack_q !== 1'b1 && n < 8) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
	endtask
endmodule

`default_nettype wire

// file: tb_top.sv
// self-checking bench for the status register hierarchy
`default_nettype none

module tb_top
	import ssrh_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic sys_clk, reset, err_entry_push, err_queue_nonempty;
	logic output_message_pending, acc_valid, acc_write;
	logic acc_ack_q, service_request_q;
	logic [REG_W-2:0] ques_cond, oper_cond;
	logic [BYTE_W-1:0] std_event_in, summary_status_byte_q;
	logic [2:0] acc_reg, acc_part;
	logic [REG_W-1:0] acc_wdata, acc_rdata_q, rnd;
	logic [REG_W:0] exp_q[$];
	logic [REG_W:0] note;
	logic [31:0] seed = 32'h0000EF10;
	int errors = 0;
	int total_checks = 0;

	ssrh_top i_dut (.sys_clk(sys_clk), .reset(reset),
		.ques_cond(ques_cond), .oper_cond(oper_cond),
		.std_event_in(std_event_in), .err_entry_push(err_entry_push),
		.err_queue_nonempty(err_queue_nonempty),
		.output_message_pending(output_message_pending),
		.acc_valid(acc_valid), .acc_write(acc_write), .acc_reg(acc_reg),
		.acc_part(acc_part), .acc_wdata(acc_wdata), .acc_ack_q(acc_ack_q),
		.acc_rdata_q(acc_rdata_q),
		.summary_status_byte_q(summary_status_byte_q),
		.service_request_q(service_request_q));

	ssrh_host_model i_host (.sys_clk(sys_clk), .acc_ack_q(acc_ack_q),
		.acc_valid(acc_valid), .acc_write(acc_write), .acc_reg(acc_reg),
		.acc_part(acc_part), .acc_wdata(acc_wdata));

	////////////////////////////////////////////////////////////////////
	// clock, random source, compare and closing tasks
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// xorshift step of the random source
	function automatic logic [31:0] xorshift(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		t = t ^ (t << 5);
		return t;
	endfunction

	task automatic next_rnd();
		seed = xorshift(seed);
		rnd = seed[15:0];
	endtask

	task automatic check(input logic [REG_W-1:0] seen,
		input logic [REG_W-1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// reads note the expected answer, writes note a blank
	task automatic rd(input logic [2:0] r, input logic [2:0] p,
		input logic [REG_W-1:0] e);
		exp_q.push_back({1'b1, e});
		i_host.access(1'b0, r, p, 16'h0000);
	endtask

	task automatic wr(input logic [2:0] r, input logic [2:0] p,
		input logic [REG_W-1:0] d);
		exp_q.push_back({1'b0, 16'h0000});
		i_host.access(1'b1, r, p, d);
	endtask

	// let status changes climb the hierarchy
	task automatic settle();
		repeat (4) @(negedge sys_clk);
	endtask

	task automatic chk_byte(input logic [BYTE_W-1:0] e, input logic s);
		check({8'h00, summary_status_byte_q}, {8'h00, e});
		check({15'h0000, service_request_q}, {15'h0000, s});
	endtask

	////////////////////////////////////////////////////////////////////
	// monitor: each answered read against the oldest note
	always @(posedge sys_clk) begin
		#1;
		if (acc_ack_q === 1'b1 && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			if (note[REG_W] === 1'b1)
				check(acc_rdata_q, note[REG_W-1:0]);
		end
	end

	// watchdog against a hang
	initial begin
		#200000;
		errors++;
		complete_run();
	end

	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [2:0] p;
		reset = 1'b1;
		ques_cond = 15'h0000;
		oper_cond = 15'h0000;
		std_event_in = 8'h00;
		err_entry_push = 1'b0;
		err_queue_nonempty = 1'b0;
		output_message_pending = 1'b0;
		repeat (16) @(negedge sys_clk);
		reset = 1'b0;
		// reset values of both generic registers and byte masks
		for (int s = 0; s < 2; s++) begin
			rd(3'(s), PART_RISE, 16'h7FFF);
			rd(3'(s), PART_FALL, 16'h0000);
			rd(3'(s), PART_EVENT, 16'h0000);
			rd(3'(s), PART_MASK, 16'h0000);
		end
		rd(SEL_REQ_MASK, 3'h0, 16'h0000);
		rd(SEL_STD_MASK, 3'h0, 16'h0000);
		// random writes, read back twice, top bit zero
		for (int k = 0; k < 3; k++) begin
			p = (k == 2) ? PART_MASK : 3'(k + 1);
			next_rnd();
			wr(SEL_OPER, p, rnd);
			rd(SEL_OPER, p, {1'b0, rnd[14:0]});
			rd(SEL_OPER, p, {1'b0, rnd[14:0]});
		end
		wr(SEL_OPER, PART_RISE, 16'hFFFF);
		wr(SEL_OPER, PART_FALL, 16'h0000);
		wr(SEL_OPER, PART_MASK, 16'h0000);
		// current part mirrors inputs, writes ignored
		next_rnd();
		@(negedge sys_clk);
		ques_cond = rnd[14:0];
		wr(SEL_QUES, PART_CURRENT, 16'hFFFF);
		settle();
		rd(SEL_QUES, PART_CURRENT, {1'b0, rnd[14:0]});
		rd(SEL_QUES, PART_CURRENT, {1'b0, rnd[14:0]});
		wr(SEL_QUES, PART_EVENT, 16'hFFFF);
		rd(SEL_QUES, PART_EVENT, {1'b0, rnd[14:0]});
		@(negedge sys_clk);
		ques_cond = 15'h0000;
		settle();
		rd(SEL_QUES, PART_EVENT, 16'h0000);
		// filters select rising and falling edges per bit
		wr(SEL_QUES, PART_RISE, 16'h0001);
		wr(SEL_QUES, PART_FALL, 16'h0002);
		@(negedge sys_clk);
		ques_cond = 15'h0003;
		settle();
		ques_cond = 15'h0000;
		settle();
		rd(SEL_QUES, PART_EVENT, 16'h0003);
		rd(SEL_QUES, PART_EVENT, 16'h0000);
		// questionable sum climbs to a service request
		wr(SEL_REQ_MASK, 3'h0, 16'h0008);
		wr(SEL_QUES, PART_MASK, 16'h0001);
		@(negedge sys_clk);
		ques_cond = 15'h0001;
		settle();
		chk_byte(8'h48, 1'b1);
		rd(SEL_SPOLL, 3'h0, 16'h0048);
		rd(SEL_SUMMARY, 3'h0, 16'h0048);
		settle();
		chk_byte(8'h48, 1'b0);
		rd(SEL_QUES, PART_EVENT, 16'h0001);
		// operation sum, mask bit six ignored
		wr(SEL_REQ_MASK, 3'h0, 16'h0040);
		wr(SEL_OPER, PART_MASK, 16'h0004);
		@(negedge sys_clk);
		oper_cond = 15'h0004;
		settle();
		chk_byte(8'h80, 1'b0);
		rd(SEL_REQ_MASK, 3'h0, 16'h0040);
		// message pending, error queue, standard events
		wr(SEL_REQ_MASK, 3'h0, 16'h0010);
		@(negedge sys_clk);
		output_message_pending = 1'b1;
		settle();
		chk_byte(8'hD0, 1'b1);
		wr(SEL_STD_MASK, 3'h0, 16'h0001);
		@(negedge sys_clk);
		err_queue_nonempty = 1'b1;
		std_event_in = 8'h01;
		@(negedge sys_clk);
		std_event_in = 8'h00;
		settle();
		chk_byte(8'hF4, 1'b1);
		// a standard event in the cycle of its read survives the clear
		fork
			rd(SEL_STD_EVT, 3'h0, 16'h0001);
			begin
				@(negedge sys_clk);
				std_event_in = 8'h02;
				@(negedge sys_clk);
				std_event_in = 8'h00;
			end
		join
		rd(SEL_STD_EVT, 3'h0, 16'h0002);
		settle();
		chk_byte(8'hD4, 1'b1);
		// each error entry requests service while bit two stands
		rd(SEL_SPOLL, 3'h0, 16'h00D4);
		wr(SEL_REQ_MASK, 3'h0, 16'h0004);
		settle();
		chk_byte(8'hD4, 1'b0);
		@(negedge sys_clk);
		err_entry_push = 1'b1;
		@(negedge sys_clk);
		err_entry_push = 1'b0;
		settle();
		chk_byte(8'hD4, 1'b1);
		// every noted access must have been answered
		check(16'(exp_q.size()), 16'h0000);
		repeat (2) @(negedge sys_clk);
		complete_run();
	end
endmodule

`default_nettype wire
